//--- dma_gate_pkg.sv
// Constants shared by the DMA helper write gate and its mask logic
package dma_gate_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_GATE = 8'h00;
   localparam logic [7:0] OFS_SHARED = 8'h04;
   localparam logic [7:0] OFS_CTRL0 = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_MASK = 8'h1C;
   localparam logic [7:0] OFS_CHAN0 = 8'h20;
   localparam logic [7:0] OFS_END = 8'h60;
   localparam logic [7:0] CTRL_STEP = 8'h04;
   localparam logic [1:0] FLD_MEM = 2'h0;
   localparam logic [1:0] FLD_IO = 2'h1;
   localparam logic [1:0] FLD_COUNT = 2'h2;
   // Widths
   localparam int GATE_W = 4;
   localparam int CTRL_W = 8;
   localparam int SHARED_W = 16;
   localparam int MEM_W = 24;
   localparam int IO_W = 16;
   localparam int COUNT_W = 16;
   // Shared control field positions; side index 0=0A 1=0B 2=1A 3=1B
   localparam int SH_FULL_LSB = 14;
   localparam int SH_SINGLE_LSB = 12;
   localparam int SH_AUX_LSB = 8;
   localparam int SH_RUN_LSB = 4;
   localparam int SH_IEN_LSB = 0;
   localparam logic [3:0] SH_LOCK_MASK = 4'hF;
   // Burst versus cycle-steal select inside a side A control register
   localparam int CTRL_BURST_BIT = 3;
   // Reset values
   localparam logic [GATE_W-1:0] RST_GATE = 4'h0;
   localparam logic [SHARED_W-1:0] RST_SHARED = 16'h0000;
   localparam logic [CTRL_W-1:0] RST_CTRL = 8'h00;
   localparam logic [MEM_W-1:0] RST_MEM = 24'h000000;
   localparam logic [IO_W-1:0] RST_IO = 16'h0000;
   localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0000;
   localparam logic [3:0] RST_IRQ = 4'h0;
endpackage

//--- write_gate_mask.sv
// Per-bit write permission for the chained transfer controller
`timescale 1ns/1ps
module write_gate_mask (
   // Gate state
   input wire logic [3:0] gate,
   input wire logic from_chain,
   // Permissions
   output logic [3:0] ctrl_ok,
   output logic [15:0] shared_mask
);
   always_comb begin
      ctrl_ok = 4'hF;
      shared_mask = 16'hFFFF;
      if (from_chain) begin
         ctrl_ok = gate;
         shared_mask = 16'h0000;
         for (int s = 0; s < 4; s++) begin
            shared_mask[dma_gate_pkg::SH_AUX_LSB + s] = gate[s];
            shared_mask[dma_gate_pkg::SH_RUN_LSB + s] = gate[s];
            shared_mask[dma_gate_pkg::SH_IEN_LSB + s] = gate[s];
         end
         // Mode selects stay with the processor
         shared_mask[15:12] = ~dma_gate_pkg::SH_LOCK_MASK;
      end
   end
endmodule

//--- dma_helper_write_gate.sv
// Register file and write gate of a four-side DMA controller on APB
// How it works
// - Gate register bits 7..4 read zero and ignore writes.
// - Gate bit 3 lets the chain controller write side 1B control and shared 11,7,3.
// - Gate bit 2 lets the chain controller write side 1A control and shared 10,6,2.
// - Gate bit 1 lets the chain controller write side 0B control and shared 9,5,1.
// - Gate bit 0 lets the chain controller write side 0A control and shared 8,4,0.
// - Processor writes pass unfiltered by the gate.
// - Chain writes to shared bits 15..12 are always dropped.
// - Chain writes set a run bit without a prior read of zero.
// - Address and count registers are always writable.
// - Short address mode runs four independent sides.
// - Full address mode pairs A with B; burst or cycle steal selectable.
// - Run bit clear with end interrupt enabled raises a transfer-end request.
`timescale 1ns/1ps
module dma_helper_write_gate #(
   parameter int NSIDE = 4
) (
   // Clock, reset, enable
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic ce,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Writer identity, valid with the request
   input wire logic chain_src,
   // Transfer engine
   input wire logic [3:0] chan_done,
   output logic [3:0] side_run,
   output logic [1:0] full_mode,
   output logic [1:0] single_mode,
   output logic [1:0] burst_sel,
   output logic [3:0] end_req,
   // Interrupt
   output logic irq
);
   generate
      if (NSIDE != 4) begin : g_bad
         $error("dma_helper_write_gate serves exactly four sides");
      end
   endgenerate

   typedef struct packed {
      logic [dma_gate_pkg::GATE_W-1:0] gate;
      logic [dma_gate_pkg::SHARED_W-1:0] shared_ctl;
      logic [3:0][dma_gate_pkg::CTRL_W-1:0] ctrl;
      logic [3:0][dma_gate_pkg::MEM_W-1:0] mem_addr;
      logic [3:0][dma_gate_pkg::IO_W-1:0] io_addr;
      logic [3:0][dma_gate_pkg::COUNT_W-1:0] xfer_count;
      logic [3:0] status;
      logic [3:0] mask;
      logic [3:0] read0;
      logic [3:0] end_q;
      logic [31:0] prdata;
      logic rd_ok;
   } state_t;

   state_t st_reg;
   state_t st_next;
   logic [3:0] ctrl_ok;
   logic [15:0] shared_mask;
   logic [3:0] end_now;

   function automatic logic mapped(input logic [7:0] a);
      return a[1:0] == 2'h0 && a < dma_gate_pkg::OFS_END && !(a >= dma_gate_pkg::OFS_CHAN0
         && a[3:2] == 2'h3);
   endfunction

   function automatic logic [7:0] ctrl_ofs(input logic [1:0] s);
      return 8'(dma_gate_pkg::OFS_CTRL0 + 8'(dma_gate_pkg::CTRL_STEP * s));
   endfunction

   write_gate_mask u_mask (
      .gate(st_reg.gate),
      .from_chain(chain_src),
      .ctrl_ok(ctrl_ok),
      .shared_mask(shared_mask)
   );

   assign end_now = ~st_reg.shared_ctl[7:4] & st_reg.shared_ctl[3:0];

   always_comb begin
      logic setup;
      logic acc;
      logic [7:0] rel;
      logic [1:0] sd;
      logic [15:0] wr_sh;
      logic [15:0] sh_new;
      logic [3:0] clr;
      logic rd_take;
      logic rd_done;
      setup = psel & ~penable;
      acc = psel & penable;
      // A read whose setup fell in a stall is captured in its first enabled access cycle
      rd_take = ~pwrite & (setup | (acc & ~st_reg.rd_ok));
      rd_done = acc & ~pwrite & st_reg.rd_ok;
      rel = 8'(paddr - dma_gate_pkg::OFS_CHAN0);
      sd = rel[5:4];
      wr_sh = 16'h0000;
      sh_new = st_reg.shared_ctl;
      clr = 4'h0;
      st_next = st_reg;
      if (ce) begin
         // Read data is captured one edge ahead so it is stable for the answering edge
         st_next.rd_ok = rd_take;
         if (rd_take) begin
            st_next.prdata = 32'h00000000;
            if (paddr == dma_gate_pkg::OFS_GATE) begin
               st_next.prdata[3:0] = st_reg.gate;
            end else if (paddr == dma_gate_pkg::OFS_SHARED) begin
               st_next.prdata[15:0] = st_reg.shared_ctl;
            end else if (paddr == dma_gate_pkg::OFS_STATUS) begin
               st_next.prdata[3:0] = st_reg.status;
            end else if (paddr == dma_gate_pkg::OFS_MASK) begin
               st_next.prdata[3:0] = st_reg.mask;
            end else if (paddr >= dma_gate_pkg::OFS_CHAN0 && mapped(paddr)) begin
               unique case (rel[3:2])
                  dma_gate_pkg::FLD_MEM: st_next.prdata[23:0] = st_reg.mem_addr[sd];
                  dma_gate_pkg::FLD_IO: st_next.prdata[15:0] = st_reg.io_addr[sd];
                  dma_gate_pkg::FLD_COUNT: st_next.prdata[15:0] = st_reg.xfer_count[sd];
                  default: st_next.prdata = 32'h00000000;
               endcase
            end else begin
               for (int s = 0; s < 4; s++) begin
                  if (paddr == ctrl_ofs(2'(s))) begin
                     st_next.prdata[7:0] = st_reg.ctrl[s];
                  end
               end
            end
         end
         if (rd_done) begin
            // Only bits actually returned are cleared, so a new event is kept
            if (paddr == dma_gate_pkg::OFS_STATUS) begin
               clr = st_reg.prdata[3:0];
            end
            if (paddr == dma_gate_pkg::OFS_SHARED && !chain_src) begin
               st_next.read0 = st_reg.read0 | ~st_reg.prdata[7:4];
            end
         end
         if (acc && pwrite) begin
            if (paddr == dma_gate_pkg::OFS_GATE && pstrb[0]) begin
               st_next.gate = pwdata[3:0];
            end
            if (paddr == dma_gate_pkg::OFS_MASK && pstrb[0]) begin
               st_next.mask = pwdata[3:0];
            end
            for (int s = 0; s < 4; s++) begin
               if (paddr == ctrl_ofs(2'(s)) && pstrb[0] && ctrl_ok[s]) begin
                  st_next.ctrl[s] = pwdata[7:0];
               end
            end
            if (paddr == dma_gate_pkg::OFS_SHARED) begin
               wr_sh = shared_mask & {{8{pstrb[1]}}, {8{pstrb[0]}}};
               sh_new = (st_reg.shared_ctl & ~wr_sh) | (pwdata[15:0] & wr_sh);
               for (int s = 0; s < 4; s++) begin
                  // Processor must have seen the run bit at zero before setting it
                  if (!chain_src && !st_reg.read0[s] && !st_reg.shared_ctl[4 + s]) begin
                     sh_new[4 + s] = 1'b0;
                  end
               end
               st_next.shared_ctl = sh_new;
               if (!chain_src) begin
                  st_next.read0 = 4'h0;
               end
            end
            if (paddr >= dma_gate_pkg::OFS_CHAN0 && mapped(paddr)) begin
               unique case (rel[3:2])
                  dma_gate_pkg::FLD_MEM: st_next.mem_addr[sd] = pwdata[23:0];
                  dma_gate_pkg::FLD_IO: st_next.io_addr[sd] = pwdata[15:0];
                  dma_gate_pkg::FLD_COUNT: st_next.xfer_count[sd] = pwdata[15:0];
                  default: st_next.prdata = st_reg.prdata;
               endcase
            end
         end
         // A finished transfer drops the run bit even against a same-cycle write
         for (int s = 0; s < 4; s++) begin
            if (chan_done[s]) begin
               st_next.shared_ctl[dma_gate_pkg::SH_RUN_LSB + s] = 1'b0;
            end
         end
         st_next.end_q = end_now;
         st_next.status = (st_reg.status & ~clr) | (end_now & ~st_reg.end_q);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st_reg.gate <= dma_gate_pkg::RST_GATE;
         st_reg.shared_ctl <= dma_gate_pkg::RST_SHARED;
         st_reg.ctrl <= {4{dma_gate_pkg::RST_CTRL}};
         st_reg.mem_addr <= {4{dma_gate_pkg::RST_MEM}};
         st_reg.io_addr <= {4{dma_gate_pkg::RST_IO}};
         st_reg.xfer_count <= {4{dma_gate_pkg::RST_COUNT}};
         st_reg.status <= dma_gate_pkg::RST_IRQ;
         st_reg.mask <= dma_gate_pkg::RST_IRQ;
         st_reg.read0 <= 4'h0;
         st_reg.end_q <= 4'h0;
         st_reg.rd_ok <= 1'b0;
         st_reg.prdata <= 32'h00000000;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata;
   // Low while the clock enable is off, plus one wait state when a read setup was frozen by it
   assign pready = ce & ~(psel & penable & ~pwrite & ~st_reg.rd_ok);
   // Blocked gate writes complete cleanly; only unmapped space errors
   assign pslverr = psel & penable & ~mapped(paddr);
   assign full_mode = st_reg.shared_ctl[15:14];
   assign single_mode = st_reg.shared_ctl[13:12];
   assign end_req = st_reg.end_q;
   assign irq = |(st_reg.status & st_reg.mask);

   always_comb begin
      side_run = st_reg.shared_ctl[7:4];
      burst_sel = 2'h0;
      for (int c = 0; c < 2; c++) begin
         if (st_reg.shared_ctl[dma_gate_pkg::SH_FULL_LSB + c]) begin
            // Paired sides run as one channel on side A
            side_run[2 * c] = st_reg.shared_ctl[4 + 2 * c] & st_reg.shared_ctl[5 + 2 * c];
            side_run[2 * c + 1] = 1'b0;
            burst_sel[c] = st_reg.ctrl[2 * c][dma_gate_pkg::CTRL_BURST_BIT];
         end
      end
   end

   logic wr_acc;
   assign wr_acc = psel & penable & pwrite & ce;

   a_gate_upper_zero: assert property (@(posedge clk_sys) disable iff (!nrst)
      psel && !penable && !pwrite && ce && paddr == dma_gate_pkg::OFS_GATE
      |=> prdata[31:4] == 28'h0000000)
      else $error("gate register upper bits not zero");
   a_gate_side_1b: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && chain_src && !st_reg.gate[3] && paddr == ctrl_ofs(2'h3)
      |=> $stable(st_reg.ctrl[3]))
      else $error("blocked chain write changed side 1B control");
   a_gate_side_1a: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && chain_src && !st_reg.gate[2] && !chan_done[2]
      && paddr == dma_gate_pkg::OFS_SHARED
      |=> $stable({st_reg.shared_ctl[10], st_reg.shared_ctl[6], st_reg.shared_ctl[2]}))
      else $error("blocked chain write changed side 1A shared bits");
   a_gate_side_0b: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && chain_src && st_reg.gate[1] && !chan_done[1] && pstrb == 4'hF
      && paddr == dma_gate_pkg::OFS_SHARED
      |=> st_reg.shared_ctl[9] == $past(pwdata[9]) && st_reg.shared_ctl[5] == $past(pwdata[5]))
      else $error("enabled chain write lost on side 0B shared bits");
   a_gate_side_0a: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && chain_src && st_reg.gate[0] && pstrb[0] && paddr == ctrl_ofs(2'h0)
      |=> st_reg.ctrl[0] == $past(pwdata[7:0]))
      else $error("enabled chain write lost on side 0A control");
   a_cpu_unfiltered: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && !chain_src && pstrb[0] && paddr == ctrl_ofs(2'h1)
      |=> st_reg.ctrl[1] == $past(pwdata[7:0]))
      else $error("processor write was filtered");
   a_mode_locked: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && chain_src && paddr == dma_gate_pkg::OFS_SHARED
      |=> $stable(st_reg.shared_ctl[15:12]))
      else $error("chain write changed mode selects");
   a_run_direct: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && chain_src && st_reg.gate[0] && pstrb[0] && pwdata[4] && !chan_done[0]
      && paddr == dma_gate_pkg::OFS_SHARED
      |=> st_reg.shared_ctl[4])
      else $error("chain write of run bit refused");
   a_addr_always: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && st_reg.gate == 4'h0 && paddr == dma_gate_pkg::OFS_CHAN0
      |=> st_reg.mem_addr[0] == $past(pwdata[23:0]))
      else $error("address register write refused");
   a_end_event: assert property (@(posedge clk_sys) disable iff (!nrst)
      ce && end_now[1] && !st_reg.end_q[1]
      |=> st_reg.status[1] && end_req[1])
      else $error("transfer end not recorded");
   a_full_pair: assert property (@(posedge clk_sys) disable iff (!nrst)
      full_mode[0] |-> !side_run[1]
      && side_run[0] == (st_reg.shared_ctl[4] && st_reg.shared_ctl[5]))
      else $error("full address pairing broken");
   a_quiet_block: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && chain_src && st_reg.gate == 4'h0 && paddr == ctrl_ofs(2'h2)
      |-> !pslverr)
      else $error("blocked write raised an error");
   a_gate_write: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && pstrb[0] && paddr == dma_gate_pkg::OFS_GATE
      |=> st_reg.gate == $past(pwdata[3:0]))
      else $error("gate register write lost");
   a_cpu_modes: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr_acc && !chain_src && pstrb[1] && paddr == dma_gate_pkg::OFS_SHARED
      |=> st_reg.shared_ctl[15:8] == $past(pwdata[15:8]))
      else $error("processor write to shared upper byte filtered");
   a_short_mode: assert property (@(posedge clk_sys) disable iff (!nrst)
      full_mode == 2'h0
      |-> side_run == st_reg.shared_ctl[7:4])
      else $error("short address sides not independent");
endmodule

//--- dtc_cpu_model.sv
// APB master standing for the processor and the chained transfer controller
`timescale 1ns/1ps
module dtc_cpu_model (
   // Clock
   input wire logic clk_sys,
   // APB master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   output logic chain_src,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] prdata
);
   logic [31:0] rd;
   logic err;
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      pstrb = 4'hF;
      chain_src = 1'b0;
   end
   // One whole transfer; the request is held until pready is seen at an edge
   task automatic xfer(input logic w, input logic c, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      chain_src <= c;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Released lines flip so a stale request cannot pass for a held one
      pwdata <= ~d;
      paddr <= ~a;
   endtask
endmodule

//--- dma_helper_write_gate_bench.sv
// Self-checking bench for the DMA helper write gate
`timescale 1ns/1ps
module dma_helper_write_gate_bench;
   logic clk_sys, nrst, ce, psel, penable, pwrite, pready, pslverr, chain_src, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, chan_done, side_run, end_req, rz;
   logic [1:0] full_mode, single_mode, burst_sel;
   logic [31:0] mr [64];
   logic [31:0] lf = 32'h46B3F18F;
   int n_errors = 0;
   int n_tests = 0;
   dtc_cpu_model u_m (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .chain_src(chain_src),
      .pready(pready), .pslverr(pslverr), .prdata(prdata));
   dma_helper_write_gate dut_u (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .chain_src(chain_src),
      .chan_done(chan_done), .side_run(side_run), .full_mode(full_mode),
      .single_mode(single_mode), .burst_sel(burst_sel), .end_req(end_req), .irq(irq));
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], 1'b0} ^ (s[31] ? 32'h04C11DB7 : 32'h00000000);
   endfunction
   function automatic logic [7:0] ao(input int i);
      if (i < 6) return 8'(4 * i);
      return 8'(32 + 16 * ((i - 6) / 3) + 4 * ((i - 6) % 3));
   endfunction
   function automatic logic [31:0] wm(input logic [7:0] a);
      if (a == 8'h00) return 32'h0000000F;
      if (a == 8'h04) return 32'h0000FFFF;
      if (a < 8'h18) return 32'h000000FF;
      if (a < 8'h20) return 32'h0000000F;
      return (a[3:0] == 4'h0) ? 32'h00FFFFFF : 32'h0000FFFF;
   endfunction
   task automatic mw(input logic c, input logic [7:0] a, input logic [31:0] d);
      logic [31:0] k;
      logic [3:0] g;
      k = wm(a);
      g = mr[0][3:0];
      if (c && a == 8'h04) k = {20'h00000, g, g, g};
      if (c && a >= 8'h08 && a < 8'h18) k = g[a[3:2] - 2'h2] ? k : 32'h00000000;
      // A processor run bit only rises after it was read back as zero
      if (!c && a == 8'h04) begin
         d[7:4] = d[7:4] & (mr[1][7:4] | rz);
         rz = 4'h0;
      end
      mr[a[7:2]] = (mr[a[7:2]] & ~k) | (d & k);
   endtask
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   task automatic wr(input logic c, input logic [7:0] a, input logic [31:0] d);
      u_m.xfer(1'b1, c, a, d);
      mw(c, a, d);
      chk(32'h00000000, {31'h0, u_m.err});
   endtask
   task automatic rd(input logic [7:0] a);
      u_m.xfer(1'b0, 1'b0, a, 32'h00000000);
      chk(mr[a[7:2]], u_m.rd);
      chk(32'h00000000, {31'h0, u_m.err});
      if (a == 8'h04) rz = rz | ~mr[1][7:4];
      if (a == 8'h18) mr[6] = 32'h00000000;
   endtask
   // Freezes the design for three edges, starting one edge after the call
   task automatic stall();
      @(posedge clk_sys);
      ce <= 1'b0;
      repeat (3) @(posedge clk_sys);
      ce <= 1'b1;
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // Whole run is about a thousand cycles; this bound only catches a hang
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      report_and_stop();
   end
   initial begin
      int i;
      nrst = 1'b0;
      ce = 1'b1;
      chan_done = 4'h0;
      rz = 4'h0;
      for (i = 0; i < 64; i++) mr[i] = 32'h00000000;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      for (i = 0; i < 20; i++) rd(i < 18 ? ao(i) : 8'(8'h18 + 4 * (i - 18)));
      $display("test reset done");
      fork
         wr(1'b0, 8'h00, 32'hFFFFFFF5);
         stall();
      join
      fork
         rd(8'h00);
         stall();
      join
      $display("test stall done");
      wr(1'b0, 8'h04, 32'h0000F000);
      wr(1'b0, 8'h00, 32'h0000000F);
      wr(1'b1, 8'h04, 32'h00000000);
      rd(8'h04);
      chk(32'h00000003, {30'h0, full_mode});
      chk(32'h00000003, {30'h0, single_mode});
      $display("test mode lock done");
      repeat (150) begin
         lf = nx(lf);
         i = int'(lf[4:0]) % 18;
         wr(lf[5], ao(i), nx(lf));
         rd(ao(i));
      end
      $display("test random done");
      wr(1'b0, 8'h04, 32'h00000000);
      rd(8'h04);
      wr(1'b0, 8'h00, 32'h00000001);
      wr(1'b1, 8'h20, lf);
      wr(1'b1, 8'h04, 32'h00000011);
      wr(1'b0, 8'h00, 32'h0000000F);
      wr(1'b1, 8'h04, 32'h000000F0);
      rd(8'h04);
      chk(32'h0000000F, {28'h0, side_run});
      wr(1'b0, 8'h04, 32'h000040F0);
      rd(8'h04);
      chk(32'h0000000D, {28'h0, side_run});
      chk({31'h0, mr[2][3]}, {30'h0, burst_sel});
      @(posedge clk_sys);
      chan_done <= 4'h2;
      @(posedge clk_sys);
      chan_done <= 4'h0;
      mr[1][5] = 1'b0;
      rd(8'h04);
      chk(32'h0000000C, {28'h0, side_run});
      $display("test rearm done");
      wr(1'b0, 8'h04, 32'h00000000);
      u_m.xfer(1'b0, 1'b0, 8'h18, 32'h00000000);
      wr(1'b0, 8'h1C, 32'h00000001);
      wr(1'b0, 8'h04, 32'h00000001);
      repeat (3) @(posedge clk_sys);
      chk(32'h00000001, {28'h0, end_req});
      chk(32'h00000001, {31'h0, irq});
      mr[6] = 32'h00000001;
      rd(8'h18);
      @(posedge clk_sys);
      chk(32'h00000000, {31'h0, irq});
      $display("test interrupt done");
      u_m.xfer(1'b1, 1'b1, 8'h2C, 32'hFFFFFFFF);
      chk(32'h00000001, {31'h0, u_m.err});
      u_m.xfer(1'b0, 1'b0, 8'h60, 32'h00000000);
      chk(32'h00000001, {31'h0, u_m.err});
      rd(8'h20);
      $display("test unmapped done");
      report_and_stop();
   end
endmodule
